// ==== logic/dtf_pkg.sv ====
`default_nettype none
package dtf_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_WORK = 8'h04;
  localparam logic [7:0] OFF_FLAGS = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_TIMER = 8'h10;
  localparam logic [7:0] OFF_LAST = 8'h14;

  // Command word fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_IMM_LSB = 16;

  // Flag bit positions
  localparam int FLAG_ZERO = 0;
  localparam int FLAG_CARRY = 1;
  localparam int FLAG_HALF = 2;
  localparam int FLAG_RANGE = 3;

  // Status bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_BIT_ERR = 1;
  localparam int ST_DROPPED = 2;

  // Bit operand fields inside the literal byte
  localparam int BIT_SEL_LSB = 0;
  localparam int BIT_IO_POS = 3;

  // Reset values
  localparam logic [7:0] WORK_RESET = 8'h00;
  localparam logic [3:0] FLAGS_RESET = 4'h0;

  // Highest address a bit operand may use
  localparam logic [7:0] BIT_ADDR_MAX = 8'h3f;

  typedef enum logic [3:0] {
    OP_MOV_IMM = 4'h0,
    OP_ST_MEM = 4'h1,
    OP_LD_MEM = 4'h2,
    OP_LD_IO = 4'h3,
    OP_ST_IO = 4'h4,
    OP_TIMER_TO_WORD = 4'h5,
    OP_ADD_MEM = 4'h6,
    OP_SUB_MEM = 4'h7,
    OP_SET_BIT = 4'h8,
    OP_CLR_BIT = 4'h9
  } dtf_op_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_HIGH = 2'b11
  } dtf_state_e;
endpackage
`default_nettype wire

// ==== logic/dtf_byte_store.sv ====
`default_nettype none
module dtf_byte_store #(
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [DEPTH];

  // Byte array in flip-flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= 8'h00;
      end
    end else if (wr_en && (int'(wr_addr) < DEPTH)) begin
      mem[wr_addr] <= wr_data;
    end
  end

  assign rd_data = (int'(rd_addr) < DEPTH) ? mem[rd_addr] : 8'h00;
endmodule
`default_nettype wire

// ==== logic/dtf_flag_alu.sv ====
`default_nettype none
module dtf_flag_alu (
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic sub,
  output logic [7:0] result,
  output logic zero,
  output logic carry,
  output logic half,
  output logic range
);
  logic [8:0] full;
  logic [4:0] low;

  always_comb begin
    if (sub) begin
      full = {1'b0, a} - {1'b0, b};
      low = {1'b0, a[3:0]} - {1'b0, b[3:0]};
    end else begin
      full = {1'b0, a} + {1'b0, b};
      low = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    end
  end

  assign result = full[7:0];
  // Zero flag from result
  assign zero = (full[7:0] == 8'h00);
  // Carry for add, borrow for subtract
  assign carry = full[8];
  // Carry or borrow out of the low nibble
  assign half = low[4];
  // Signed overflow from operand and result signs
  assign range = sub ? ((a[7] ^ b[7]) & (a[7] ^ full[7]))
                     : (~(a[7] ^ b[7]) & (a[7] ^ full[7]));
endmodule
`default_nettype wire

// ==== logic/dtf_core.sv ====
// Design decisions made here: the register offsets and the APB slave port.
`default_nettype none
module dtf_core #(
  parameter int MEM_DEPTH = 256,
  parameter int IO_DEPTH = 64,
  parameter int IO_AW = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic [15:0] timer_count,
  output logic [7:0] work_register,
  output logic [3:0] flags,
  output logic busy
);
  dtf_pkg::dtf_state_e state;
  dtf_pkg::dtf_state_e next_state;

  logic [3:0] cmd_op;
  logic [7:0] cmd_addr;
  logic [7:0] cmd_imm;
  logic [15:0] timer_hold;
  logic bit_err;
  logic dropped;

  logic apb_write;
  logic apb_read;
  logic cmd_write;
  logic cmd_start;
  logic addr_ok;

  logic mem_we;
  logic [7:0] mem_wa;
  logic [7:0] mem_wd;
  logic [7:0] mem_rd;
  logic io_we;
  logic [7:0] io_wd;
  logic [7:0] io_rd;
  logic io_in_range;

  logic work_we;
  logic [7:0] next_work;
  logic flags_we;
  logic [3:0] next_flags;
  logic bit_err_set;

  logic [7:0] alu_result;
  logic alu_zero;
  logic alu_carry;
  logic alu_half;
  logic alu_range;

  logic [7:0] bit_mask;
  logic bit_target_io;
  logic [7:0] bit_src;

  // Bit operand address check
  function automatic logic bit_addr_ok(input logic [7:0] a);
    bit_addr_ok = (a <= dtf_pkg::BIT_ADDR_MAX);
  endfunction

  // Register offset decode
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a[1:0] == 2'b00) && (a < dtf_pkg::OFF_LAST);
  endfunction

  // APB slave, zero wait states
  assign pready = 1'b1;
  assign apb_write = psel && penable && pwrite;
  assign apb_read = psel && penable && !pwrite;
  assign addr_ok = is_mapped(paddr);
  assign cmd_write = apb_write && (paddr == dtf_pkg::OFF_CMD);
  assign cmd_start = cmd_write && (state == dtf_pkg::ST_IDLE);
  assign busy = (state != dtf_pkg::ST_IDLE);

  // Unmapped, misaligned or read-only writes answer with an error
  always_comb begin
    pslverr = 1'b0;
    if (psel && penable) begin
      if (!addr_ok) begin
        pslverr = 1'b1;
      end else if (pwrite && (paddr == dtf_pkg::OFF_TIMER)) begin
        pslverr = 1'b1;
      end else if (!pwrite && (paddr == dtf_pkg::OFF_CMD)) begin
        pslverr = 1'b0;
      end
    end
  end

  // Read data mux
  always_comb begin
    prdata = 32'h0000_0000;
    if (apb_read) begin
      case (paddr)
        dtf_pkg::OFF_CMD: begin
          prdata = {8'h00, cmd_imm, cmd_addr, 4'h0, cmd_op};
        end
        dtf_pkg::OFF_WORK: begin
          prdata = {24'h00_0000, work_register};
        end
        dtf_pkg::OFF_FLAGS: begin
          prdata = {28'h000_0000, flags};
        end
        dtf_pkg::OFF_STATUS: begin
          prdata = {29'h0000_0000, dropped, bit_err, busy};
        end
        dtf_pkg::OFF_TIMER: begin
          prdata = {16'h0000, timer_count};
        end
        default: begin
          prdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // Command capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_op <= 4'h0;
      cmd_addr <= 8'h00;
      cmd_imm <= 8'h00;
    end else if (cmd_start) begin
      cmd_op <= pwdata[dtf_pkg::CMD_OP_LSB +: 4];
      cmd_addr <= pwdata[dtf_pkg::CMD_ADDR_LSB +: 8];
      cmd_imm <= pwdata[dtf_pkg::CMD_IMM_LSB +: 8];
    end
  end

  // Sequencer
  always_comb begin
    case (state)
      dtf_pkg::ST_IDLE: begin
        next_state = cmd_start ? dtf_pkg::ST_EXEC : dtf_pkg::ST_IDLE;
      end
      dtf_pkg::ST_EXEC: begin
        if (cmd_op == dtf_pkg::OP_TIMER_TO_WORD) begin
          next_state = dtf_pkg::ST_HIGH;
        end else begin
          next_state = dtf_pkg::ST_IDLE;
        end
      end
      dtf_pkg::ST_HIGH: begin
        next_state = dtf_pkg::ST_IDLE;
      end
      default: begin
        next_state = dtf_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= dtf_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Whole timer count latched once so both bytes match
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_hold <= 16'h0000;
    end else if (state == dtf_pkg::ST_EXEC &&
                 cmd_op == dtf_pkg::OP_TIMER_TO_WORD) begin
      timer_hold <= timer_count;
    end
  end

  // Arithmetic on work register and memory byte
  dtf_flag_alu u_alu (
    .a(work_register),
    .b(mem_rd),
    .sub(cmd_op == dtf_pkg::OP_SUB_MEM),
    .result(alu_result),
    .zero(alu_zero),
    .carry(alu_carry),
    .half(alu_half),
    .range(alu_range)
  );

  // Bit operand decode
  assign bit_mask = 8'h01 << cmd_imm[dtf_pkg::BIT_SEL_LSB +: 3];
  assign bit_target_io = cmd_imm[dtf_pkg::BIT_IO_POS];
  assign bit_src = bit_target_io ? io_rd : mem_rd;
  assign io_in_range = (int'(cmd_addr) < IO_DEPTH);

  // Execution
  always_comb begin
    work_we = 1'b0;
    next_work = work_register;
    flags_we = 1'b0;
    next_flags = flags;
    mem_we = 1'b0;
    mem_wa = cmd_addr;
    mem_wd = work_register;
    io_we = 1'b0;
    io_wd = work_register;
    bit_err_set = 1'b0;
    if (state == dtf_pkg::ST_EXEC) begin
      case (cmd_op)
        dtf_pkg::OP_MOV_IMM: begin
          work_we = 1'b1;
          next_work = cmd_imm;
        end
        dtf_pkg::OP_ST_MEM: begin
          mem_we = 1'b1;
        end
        dtf_pkg::OP_LD_MEM: begin
          work_we = 1'b1;
          next_work = mem_rd;
          flags_we = 1'b1;
          next_flags[dtf_pkg::FLAG_ZERO] = (mem_rd == 8'h00);
        end
        dtf_pkg::OP_LD_IO: begin
          work_we = 1'b1;
          next_work = io_in_range ? io_rd : 8'h00;
          flags_we = 1'b1;
          next_flags[dtf_pkg::FLAG_ZERO] = (next_work == 8'h00);
        end
        dtf_pkg::OP_ST_IO: begin
          io_we = io_in_range;
        end
        dtf_pkg::OP_TIMER_TO_WORD: begin
          mem_we = 1'b1;
          mem_wd = timer_count[7:0];
        end
        dtf_pkg::OP_ADD_MEM, dtf_pkg::OP_SUB_MEM: begin
          work_we = 1'b1;
          next_work = alu_result;
          flags_we = 1'b1;
          next_flags[dtf_pkg::FLAG_ZERO] = alu_zero;
          next_flags[dtf_pkg::FLAG_CARRY] = alu_carry;
          next_flags[dtf_pkg::FLAG_HALF] = alu_half;
          next_flags[dtf_pkg::FLAG_RANGE] = alu_range;
        end
        dtf_pkg::OP_SET_BIT, dtf_pkg::OP_CLR_BIT: begin
          if (!bit_addr_ok(cmd_addr)) begin
            bit_err_set = 1'b1;
          end else begin
            if (cmd_op == dtf_pkg::OP_SET_BIT) begin
              mem_wd = bit_src | bit_mask;
            end else begin
              mem_wd = bit_src & ~bit_mask;
            end
            io_wd = mem_wd;
            io_we = bit_target_io && io_in_range;
            mem_we = !bit_target_io;
          end
        end
        default: begin
          work_we = 1'b0;
        end
      endcase
    end else if (state == dtf_pkg::ST_HIGH) begin
      mem_we = 1'b1;
      mem_wa = cmd_addr + 8'h01;
      mem_wd = timer_hold[15:8];
    end
  end

  // Work register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      work_register <= dtf_pkg::WORK_RESET;
    end else if (work_we) begin
      work_register <= next_work;
    end else if (apb_write && paddr == dtf_pkg::OFF_WORK) begin
      work_register <= pwdata[7:0];
    end
  end

  // Status flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= dtf_pkg::FLAGS_RESET;
    end else if (flags_we) begin
      flags <= next_flags;
    end else if (apb_write && paddr == dtf_pkg::OFF_FLAGS) begin
      flags <= pwdata[3:0];
    end
  end

  // Sticky status, write one to clear, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_err <= 1'b0;
      dropped <= 1'b0;
    end else begin
      if (bit_err_set) begin
        bit_err <= 1'b1;
      end else if (apb_write && paddr == dtf_pkg::OFF_STATUS &&
                   pwdata[dtf_pkg::ST_BIT_ERR]) begin
        bit_err <= 1'b0;
      end
      if (cmd_write && busy) begin
        dropped <= 1'b1;
      end else if (apb_write && paddr == dtf_pkg::OFF_STATUS &&
                   pwdata[dtf_pkg::ST_DROPPED]) begin
        dropped <= 1'b0;
      end
    end
  end

  // Data memory
  dtf_byte_store #(
    .DEPTH(MEM_DEPTH),
    .AW(8)
  ) u_data_mem (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(mem_we),
    .wr_addr(mem_wa),
    .wr_data(mem_wd),
    .rd_addr(cmd_addr),
    .rd_data(mem_rd)
  );

  // IO register space
  dtf_byte_store #(
    .DEPTH(IO_DEPTH),
    .AW(IO_AW)
  ) u_io_space (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(io_we),
    .wr_addr(cmd_addr[IO_AW-1:0]),
    .wr_data(io_wd),
    .rd_addr(cmd_addr[IO_AW-1:0]),
    .rd_data(io_rd)
  );
endmodule
`default_nettype wire

// ==== testbench/dtf_core_props.sv ====
`default_nettype none
module dtf_core_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic [15:0] timer_count,
  input wire logic [7:0] work_register,
  input wire logic [3:0] flags,
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic go;
  logic [3:0] op;
  assign go = psel && penable && pwrite && paddr == 8'h00 && !busy;
  assign op = pwdata[3:0];
  function automatic logic [3:0] add_f(logic [7:0] a, logic [7:0] r);
    logic [7:0] b;
    b = r - a;
    return {a[7] == b[7] && r[7] != a[7], r[3:0] < a[3:0], r < a, r == 0};
  endfunction
  a_mov_literal: assert property (
    go && op == 4'h0 |-> ##2 work_register == $past(pwdata[23:16], 2)
    && flags == $past(flags, 2)) else $error("literal move wrong");
  a_busy_one: assert property (
    go && op != 4'h5 |=> busy ##1 !busy) else $error("busy length wrong");
  a_busy_two: assert property (
    go && op == 4'h5 |=> busy [*2] ##1 !busy) else $error("timer busy wrong");
  a_store_kept: assert property (
    go && (op == 4'h1 || op == 4'h4 || op == 4'h5) |-> ##3
    flags == $past(flags, 3) && work_register == $past(work_register, 3))
    else $error("store changed state");
  a_load_zero: assert property (
    go && (op == 4'h2 || op == 4'h3) |-> ##2
    flags[0] == (work_register == 8'h00) && flags[3:1] == $past(flags[3:1], 2))
    else $error("load flags wrong");
  a_add_flags: assert property (
    go && op == 4'h6 |-> ##2
    flags == add_f($past(work_register, 2), work_register))
    else $error("add flags wrong");
  a_sub_borrow: assert property (
    go && op == 4'h7 |-> ##2 flags[0] == (work_register == 8'h00)
    && flags[1] == (work_register > $past(work_register, 2)))
    else $error("borrow wrong");
  a_bit_range: assert property (
    go && (op == 4'h8 || op == 4'h9) && pwdata[15:8] > 8'h3f |-> ##2
    work_register == $past(work_register, 2) && flags == $past(flags, 2))
    else $error("bit op out of range acted");
endmodule
bind dtf_core dtf_core_props u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .timer_count(timer_count), .work_register(work_register), .flags(flags),
  .busy(busy));
`default_nettype wire

// ==== testbench/dtf_timer_model.sv ====
`default_nettype none
module dtf_timer_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic load,
  input wire logic [15:0] load_value,
  output logic [15:0] count
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 16'h0000;
    end else if (load) begin
      count <= load_value;
    end else if (run) begin
      count <= count + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/test_data_transfer_and_flags.sv ====
`default_nettype none
module test_data_transfer_and_flags;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, busy;
  logic [7:0] paddr, work_register;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] timer_count;
  logic [3:0] flags;
  logic run, load, err;
  int fails, comparisons;
  // Op, addr, literal, work, flags, flag mask
  logic [35:0] rows [21] = '{
    36'h0_00_80_80_0_f, 36'h1_10_00_80_0_f,
    36'h6_10_00_00_b_f, 36'h0_00_0f_0f_b_f,
    36'h4_05_00_0f_b_f, 36'h0_00_01_01_b_f,
    36'h1_11_00_01_b_f, 36'h3_05_00_0f_a_f,
    36'h6_11_00_10_4_f, 36'h7_10_00_90_a_b,
    36'h2_12_00_00_b_b, 36'h5_20_00_00_b_b,
    36'h2_20_00_00_b_b, 36'h2_21_00_5a_a_b,
    36'h8_3f_0b_5a_a_b, 36'h3_3f_00_08_a_b,
    36'h9_3f_0b_08_a_b, 36'h3_3f_00_00_b_b,
    36'h8_40_02_00_b_b, 36'h2_40_00_00_b_b,
    36'h3_45_00_00_b_b};
  dtf_core u_dtf_core (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .timer_count(timer_count), .work_register(work_register),
    .flags(flags), .busy(busy));
  dtf_timer_model u_dtf_timer_model (.pclk(pclk), .presetn(presetn),
    .run(run), .load(load), .load_value(16'h5a00), .count(timer_count));
  task automatic check(logic [31:0] got, logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic keep);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    penable <= 1'b0;
    if (!keep) begin
      psel <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task automatic cmd(logic [3:0] o, logic [7:0] a, logic [7:0] l);
    apb(1'b1, 8'h00, {8'h00, l, a, 4'h0, o}, 1'b0);
    rd = 32'h1;
    while (rd[0] !== 1'b0) apb(1'b0, 8'h0c, 32'h0, 1'b0);
  endtask
  task automatic results();
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    #20000;
    fails++;
    results();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    run = 1'b1;
    load = 1'b0;
    fails = 0;
    comparisons = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h04, 32'h0, 1'b1);
    check(rd, 32'h0);
    apb(1'b0, 8'h08, 32'h0, 1'b1);
    check(rd, 32'h0);
    apb(1'b0, 8'h0c, 32'h0, 1'b0);
    check(rd, 32'h0);
    load <= 1'b1;
    run <= 1'b0;
    @(posedge pclk);
    load <= 1'b0;
    foreach (rows[i]) begin
      cmd(rows[i][35:32], rows[i][31:24], rows[i][23:16]);
      apb(1'b0, 8'h04, 32'h0, 1'b1);
      check(rd, {24'h0, rows[i][15:8]});
      apb(1'b0, 8'h08, 32'h0, 1'b0);
      check(rd & {28'h0, rows[i][3:0]}, {28'h0, rows[i][7:4]});
    end
    apb(1'b0, 8'h0c, 32'h0, 1'b0);
    check(rd, 32'h2);
    apb(1'b1, 8'h0c, 32'h6, 1'b1);
    apb(1'b1, 8'h00, 32'h0000_3005, 1'b1);
    apb(1'b1, 8'h00, 32'h0077_0000, 1'b0);
    apb(1'b0, 8'h0c, 32'h0, 1'b1);
    check(rd, 32'h4);
    apb(1'b0, 8'h04, 32'h0, 1'b1);
    check(rd, 32'h0);
    apb(1'b0, 8'h10, 32'h0, 1'b1);
    check(rd, 32'h5a00);
    apb(1'b0, 8'h18, 32'h0, 1'b1);
    check(rd, 32'h0);
    check({31'h0, err}, 32'h1);
    apb(1'b1, 8'h10, 32'h1, 1'b0);
    check(err, 1'b1);
    // Bus writes to work and flags, then a reset in mid-run
    apb(1'b1, 8'h04, 32'h3c, 1'b1);
    apb(1'b1, 8'h08, 32'h5, 1'b1);
    apb(1'b0, 8'h04, 32'h0, 1'b1);
    check(rd, 32'h3c);
    apb(1'b0, 8'h08, 32'h0, 1'b0);
    check(rd, 32'h5);
    presetn <= 1'b0;
    @(posedge pclk);
    check({18'h0, pslverr, busy, flags, work_register}, 32'h0);
    check({31'h0, pready}, 32'h1);
    check(prdata, 32'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h0c, 32'h0, 1'b1);
    check(rd, 32'h0);
    apb(1'b0, 8'h04, 32'h0, 1'b0);
    check(rd, 32'h0);
    results();
  end
endmodule
`default_nettype wire
